//--- src/dpcs_pkg.sv
// package: constants for the ddr2 power-down clock-change and odt sequencer
package dpcs_pkg;
    // apb register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS = 8'h08;
    // ctrl fields (write 1 to start; self clearing)
    localparam int CTRL_FCHG_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_ODTON_BIT = 2;
    localparam int CTRL_ODTOFF_BIT = 3;
    localparam int CTRL_RTT_BIT = 4;
    localparam int CTRL_CLKOK_BIT = 5;
    // mode fields
    localparam int MODE_SLOWEXIT_BIT = 12;
    localparam int MODE_RTT_LSB = 0;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_DESEL = 4'hF;
    localparam logic [3:0] CMD_LM = 4'h0;
    // mode-register bank selects
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;
    localparam logic [12:0] MR_DLL_RESET = 13'h0100;
    localparam logic [12:0] EMR_RTT_MASK = 13'h0044;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int TCKE_CYC = 3;
    localparam int PD_TO_FCHG_CYC = 2;
    localparam int CLK_STABLE_CYC = 1;
    localparam int RELOCK_CYC = 200;
    localparam int TMOD_NS = 12;
    localparam int TMOD_CYC = (TMOD_NS * CLK_MHZ + 999) / 1000;
    localparam int TAOFD_CYC = 3;
    localparam int TANPD_CYC = 4;
    localparam int TAXPD_CYC = 8;
    localparam int TDELAY_CYC = 4;
    // reset values
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PDE = 4'h1,
        ST_PDWAIT = 4'h2,
        ST_FCHG = 4'h3,
        ST_PDX = 4'h4,
        ST_DLLRST = 4'h5,
        ST_RELOCK = 4'h6,
        ST_RSTLOW = 4'h7,
        ST_RSTCLK = 4'h8,
        ST_ODTOFF = 4'h9,
        ST_RTTLM = 4'hA,
        ST_TMOD = 4'hB
    } dpcs_state_t;
endpackage : dpcs_pkg

//--- src/dpcs_seq.sv
// design: apb-controlled ddr2 power-down, clock change, cke reset and odt sequencer
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module dpcs_seq (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic CKE_O,
    output logic ODT_O,
    output logic CK_EN_O,
    output logic CLK_SEL_O,
    output logic [3:0] CMD_O,
    output logic [1:0] BA_O,
    output logic [12:0] ADDR_O
);
    ////////////////////////////////////////////////////////////////////////
    dpcs_pkg::dpcs_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    logic [31:0] mode_q;
    logic [5:0] go_q;
    logic cke_q, odt_q, cken_q, clksel_q, odt_en_q, odt_async_q;
    logic [3:0] cmd_q;
    logic [1:0] ba_q;
    logic [12:0] addr_q;
    logic [7:0] since_pd_q;
    logic [31:0] rdata_q;
    logic pslverr_q;
    logic busy;
    logic wr_en, rd_en, addr_ok;
    logic cnt_done;

    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign addr_ok = (PADDR_I == dpcs_pkg::CTRL_OFS) || (PADDR_I == dpcs_pkg::STAT_OFS)
        || (PADDR_I == dpcs_pkg::MODE_OFS);
    assign busy = (st_q != dpcs_pkg::ST_IDLE) && (st_q != dpcs_pkg::ST_PDWAIT)
        && (st_q != dpcs_pkg::ST_FCHG) && (st_q != dpcs_pkg::ST_RSTCLK);
    assign cnt_done = (cnt_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait-free access, reads sampled in setup
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode_q <= dpcs_pkg::MODE_RST;
            go_q <= 6'h00;
            rdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            go_q <= 6'h00;
            // flagged at setup so the access phase sees it from a flop
            pslverr_q <= PSEL_I && !PENABLE_I && !addr_ok;
            if (wr_en && PADDR_I == dpcs_pkg::CTRL_OFS) begin
                go_q <= PWDATA_I[5:0];
            end
            if (wr_en && PADDR_I == dpcs_pkg::MODE_OFS && !busy) begin
                mode_q <= PWDATA_I;
            end
            if (rd_en) begin
                case (PADDR_I)
                    dpcs_pkg::CTRL_OFS: rdata_q <= 32'h0000_0000;
                    dpcs_pkg::STAT_OFS: rdata_q <= {16'h0000, since_pd_q, odt_async_q,
                        odt_en_q, busy, cke_q, st_q};
                    dpcs_pkg::MODE_OFS: rdata_q <= mode_q;
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign PRDATA_O = rdata_q;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_done ? 8'h00 : cnt_q - 8'h01;
        case (st_q)
            dpcs_pkg::ST_IDLE: begin
                if (go_q[dpcs_pkg::CTRL_FCHG_BIT]) begin
                    st_d = dpcs_pkg::ST_PDE;
                    cnt_d = 8'(dpcs_pkg::TAOFD_CYC);
                end else if (go_q[dpcs_pkg::CTRL_RST_BIT]) begin
                    st_d = dpcs_pkg::ST_RSTLOW;
                    cnt_d = 8'(dpcs_pkg::TDELAY_CYC);
                end else if (go_q[dpcs_pkg::CTRL_RTT_BIT]) begin
                    st_d = dpcs_pkg::ST_ODTOFF;
                    cnt_d = 8'(dpcs_pkg::TAOFD_CYC);
                end
            end
            dpcs_pkg::ST_PDE: if (cnt_done) begin
                st_d = dpcs_pkg::ST_PDWAIT;
                cnt_d = 8'(dpcs_pkg::PD_TO_FCHG_CYC);
            end
            dpcs_pkg::ST_PDWAIT: if (cnt_done) begin
                st_d = dpcs_pkg::ST_FCHG;
            end
            dpcs_pkg::ST_FCHG: if (go_q[dpcs_pkg::CTRL_CLKOK_BIT]) begin
                st_d = dpcs_pkg::ST_PDX;
                cnt_d = 8'(dpcs_pkg::CLK_STABLE_CYC + dpcs_pkg::TCKE_CYC);
            end
            dpcs_pkg::ST_PDX: if (cnt_done) begin
                st_d = dpcs_pkg::ST_DLLRST;
            end
            dpcs_pkg::ST_DLLRST: begin
                st_d = dpcs_pkg::ST_RELOCK;
                cnt_d = 8'(dpcs_pkg::RELOCK_CYC);
            end
            dpcs_pkg::ST_RELOCK: if (cnt_done) begin
                st_d = dpcs_pkg::ST_IDLE;
            end
            dpcs_pkg::ST_RSTLOW: if (cnt_done) begin
                st_d = dpcs_pkg::ST_RSTCLK;
            end
            dpcs_pkg::ST_RSTCLK: if (go_q[dpcs_pkg::CTRL_CLKOK_BIT]) begin
                st_d = dpcs_pkg::ST_PDX;
                cnt_d = 8'(dpcs_pkg::CLK_STABLE_CYC + dpcs_pkg::TCKE_CYC);
            end
            dpcs_pkg::ST_ODTOFF: if (cnt_done) begin
                st_d = dpcs_pkg::ST_RTTLM;
            end
            dpcs_pkg::ST_RTTLM: begin
                st_d = dpcs_pkg::ST_TMOD;
                cnt_d = 8'(dpcs_pkg::TMOD_CYC);
            end
            dpcs_pkg::ST_TMOD: if (cnt_done) begin
                st_d = dpcs_pkg::ST_IDLE;
            end
            default: st_d = dpcs_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, all registered
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_q <= dpcs_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            cke_q <= 1'b0;
            odt_q <= 1'b0;
            cken_q <= 1'b1;
            clksel_q <= 1'b0;
            cmd_q <= dpcs_pkg::CMD_NOP;
            ba_q <= 2'h0;
            addr_q <= 13'h0000;
            odt_en_q <= 1'b0;
            since_pd_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cmd_q <= dpcs_pkg::CMD_NOP;
            // dll reset and termination writes are the only commands issued here
            if (st_q == dpcs_pkg::ST_DLLRST) begin
                cmd_q <= dpcs_pkg::CMD_LM;
                ba_q <= dpcs_pkg::BA_MR;
                addr_q <= mode_q[12:0] | dpcs_pkg::MR_DLL_RESET;
            end
            if (st_q == dpcs_pkg::ST_RTTLM) begin
                cmd_q <= dpcs_pkg::CMD_LM;
                ba_q <= dpcs_pkg::BA_EMR;
                addr_q <= mode_q[28:16] & dpcs_pkg::EMR_RTT_MASK;
            end
            // cke low while power-down, clock change and reset are pending
            cke_q <= !(st_d inside {dpcs_pkg::ST_PDWAIT, dpcs_pkg::ST_FCHG,
                dpcs_pkg::ST_RSTLOW, dpcs_pkg::ST_RSTCLK}) && (st_q != dpcs_pkg::ST_PDX
                || cnt_q <= 8'(dpcs_pkg::TCKE_CYC));
            cken_q <= !(st_q inside {dpcs_pkg::ST_FCHG, dpcs_pkg::ST_RSTCLK});
            if (st_q == dpcs_pkg::ST_FCHG && go_q[dpcs_pkg::CTRL_CLKOK_BIT]) begin
                clksel_q <= !clksel_q;
            end
            if (st_q == dpcs_pkg::ST_TMOD && cnt_done) begin
                odt_en_q <= 1'b1;
            end
            if (st_q == dpcs_pkg::ST_RSTLOW) begin
                odt_en_q <= 1'b0;
            end
            // odt only from idle and only when enabled; forced low otherwise
            // leaving idle drops odt at once: with cke on reset, four cycles before cke on power-down
            if (st_q != dpcs_pkg::ST_IDLE || st_d != dpcs_pkg::ST_IDLE || !odt_en_q) begin
                odt_q <= 1'b0;
            end else if (go_q[dpcs_pkg::CTRL_ODTON_BIT]) begin
                odt_q <= 1'b1;
            end else if (go_q[dpcs_pkg::CTRL_ODTOFF_BIT]) begin
                odt_q <= 1'b0;
            end
            since_pd_q <= (cke_q == 1'b0) ? 8'h00
                : (since_pd_q == 8'hFF ? 8'hFF : since_pd_q + 8'h01);
        end
    end

    // timing class: asynchronous in slow-exit pd, with cke low while busy, or near pd exit
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            odt_async_q <= 1'b0;
        end else begin
            odt_async_q <= (!cke_q && mode_q[dpcs_pkg::MODE_SLOWEXIT_BIT])
                || (!cke_q && busy)
                || (cke_q && since_pd_q < 8'(dpcs_pkg::TAXPD_CYC));
        end
    end

    assign CKE_O = cke_q;
    assign ODT_O = odt_q;
    assign CK_EN_O = cken_q;
    assign CLK_SEL_O = clksel_q;
    assign CMD_O = cmd_q;
    assign BA_O = ba_q;
    assign ADDR_O = addr_q;

    ////////////////////////////////////////////////////////////////////////
    chk_odt_relock: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_RELOCK |-> !odt_q) else $error("odt high in relock");
    chk_fchg_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_FCHG |-> !cke_q && !odt_q) else $error("pins moved in change");
    chk_dll_rst: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_DLLRST |=> cmd_q == dpcs_pkg::CMD_LM && addr_q[8])
        else $error("no dll reset");
    chk_cke_high: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $rose(cke_q) |-> cke_q [*3]) else $error("cke high too short");
    chk_cke_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(cke_q) |-> !cke_q [*3]) else $error("cke low too short");
    chk_ckstop: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(cken_q) |-> $past(!cke_q, 2)) else $error("clock stopped early");
    chk_odt_en: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        odt_q |-> odt_en_q) else $error("odt before enable");
    chk_rst_cmd: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !cke_q |-> cmd_q == dpcs_pkg::CMD_NOP) else $error("command during reset");
    chk_tmod: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_RTTLM |=> !odt_q [*2]) else $error("odt in tmod");
    cov_fchg: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_FCHG ##[1:50] st_q == dpcs_pkg::ST_RELOCK);
    cov_rst: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_RSTCLK ##[1:50] st_q == dpcs_pkg::ST_PDX);
    cov_rtt: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_q == dpcs_pkg::ST_RTTLM);
endmodule : dpcs_seq
`default_nettype wire

//--- verification/dpcs_dram_model.sv
// partner: behavioural ddr2 device watching the controller's pins
`timescale 1ns/100ps
`default_nettype none
module dpcs_dram_model (
    input wire logic clk_i,
    input wire logic ck_en_i,
    input wire logic cke_i,
    input wire logic odt_i,
    input wire logic [3:0] cmd_i,
    input wire logic [1:0] ba_i,
    input wire logic [12:0] addr_i,
    output logic [7:0] viol_o,
    output logic [7:0] dll_rst_o,
    output logic [1:0] rtt_o,
    output logic async_o
);
    int run_q = 3;
    int relock_q = 0;
    int tmod_q = 0;
    logic cke_q = 1'b0;
    logic en_q = 1'b1;
    logic odt_en_q = 1'b0;
    wire logic idle_cmd;
    assign idle_cmd = (cmd_i == dpcs_pkg::CMD_NOP) || (cmd_i == dpcs_pkg::CMD_DESEL);
    // only precharge power-down is ever entered here, so cke low means async class
    assign async_o = !cke_q;
    initial begin
        viol_o = 8'h00;
        dll_rst_o = 8'h00;
        rtt_o = 2'h0;
    end
    // the device sees no edge while the controller holds the clock off
    always @(posedge clk_i) begin
        en_q <= ck_en_i;
        if (!ck_en_i && en_q && (cke_q || run_q < dpcs_pkg::PD_TO_FCHG_CYC)) begin
            viol_o <= viol_o + 8'h01;
        end
        if (ck_en_i && !en_q && cke_i) begin
            viol_o <= viol_o + 8'h01;
        end
        if (ck_en_i) begin
            run_q <= (cke_i == cke_q) ? run_q + 1 : 1;
            cke_q <= cke_i;
            relock_q <= (relock_q > 0) ? relock_q - 1 : 0;
            tmod_q <= (tmod_q > 0) ? tmod_q - 1 : 0;
            if (cke_i != cke_q && run_q < dpcs_pkg::TCKE_CYC) begin
                viol_o <= viol_o + 8'h01;
            end
            // with cke low every other pin is ignored, yet only nop or deselect is legal there
            if ((!cke_i || !cke_q) && !idle_cmd) begin
                viol_o <= viol_o + 8'h01;
            end
            if (odt_i && (!cke_i || relock_q > 0 || tmod_q > 0 || !odt_en_q)) begin
                viol_o <= viol_o + 8'h01;
            end
            if (cke_i && cmd_i == dpcs_pkg::CMD_LM && ba_i == dpcs_pkg::BA_MR && addr_i[8]) begin
                dll_rst_o <= dll_rst_o + 8'h01;
                relock_q <= dpcs_pkg::RELOCK_CYC;
            end
            if (cke_i && cmd_i == dpcs_pkg::CMD_LM && ba_i == dpcs_pkg::BA_EMR) begin
                rtt_o <= {addr_i[6], addr_i[2]};
                odt_en_q <= addr_i[6] | addr_i[2];
                tmod_q <= dpcs_pkg::TMOD_CYC;
            end
        end
    end
endmodule : dpcs_dram_model
`default_nettype wire

//--- verification/tb_dpcs_seq.sv
// testbench: apb-driven scenarios for the power-down, clock change and odt sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_dpcs_seq;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cke, odt, ck_en, clk_sel;
    logic err, async_cls, sel0;
    logic [7:0] paddr, viol, dll, dll0;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] cmd;
    logic [1:0] ba, rtt;
    logic [12:0] addr;
    int n_errors = 0;
    int n_checks = 0;
    dpcs_seq u_dut (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CKE_O(cke), .ODT_O(odt), .CK_EN_O(ck_en),
        .CLK_SEL_O(clk_sel), .CMD_O(cmd), .BA_O(ba), .ADDR_O(addr));
    dpcs_dram_model u_dram (.clk_i(clk), .ck_en_i(ck_en), .cke_i(cke), .odt_i(odt),
        .cmd_i(cmd), .ba_i(ba), .addr_i(addr), .viol_o(viol), .dll_rst_o(dll),
        .rtt_o(rtt), .async_o(async_cls));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task timeout(input string what);
        n_errors++;
        $display("Error at %0t: timeout %s", $time, what);
        stop_test;
    endtask : timeout
    // one apb transfer; read data and slave error taken at the completing edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) timeout("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_idle;
        int n;
        n = 0;
        // let a just-written start pulse reach the state before polling
        repeat (2) @(posedge clk);
        do begin
            apb(1'b0, dpcs_pkg::STAT_OFS, 32'h0);
            n++;
        end while (rd[5] !== 1'b0 && n < 300);
        if (rd[5] !== 1'b0) timeout("busy");
    endtask : wait_idle
    task wait_clk_off;
        int n;
        n = 0;
        while (ck_en !== 1'b0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (ck_en !== 1'b0) timeout("clock stop");
    endtask : wait_clk_off
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        apb(1'b0, dpcs_pkg::MODE_OFS, 32'h0);
        chk(rd, dpcs_pkg::MODE_RST, "mode reset");
        apb(1'b0, dpcs_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "ctrl read");
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped err");
        $display("test regs done");
    endtask : t_regs
    task t_rtt;
        apb(1'b1, dpcs_pkg::MODE_OFS, 32'h0044_1000);
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_RTT_BIT);
        wait_idle;
        chk({31'h0, rd[6]}, 32'h1, "odt enabled");
        chk({30'h0, rtt}, 32'h3, "rtt value");
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_ODTON_BIT);
        repeat (3) @(posedge clk);
        chk({31'h0, odt}, 32'h1, "odt on");
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_ODTOFF_BIT);
        repeat (3) @(posedge clk);
        chk({31'h0, odt}, 32'h0, "odt off");
        $display("test rtt done");
    endtask : t_rtt
    task t_fchg;
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_ODTON_BIT);
        sel0 = clk_sel;
        dll0 = dll;
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_FCHG_BIT);
        wait_clk_off;
        chk({30'h0, cke, odt}, 32'h0, "cke odt low");
        apb(1'b0, dpcs_pkg::STAT_OFS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, dpcs_pkg::ST_FCHG}, "state fchg");
        chk({31'h0, rd[7]}, 32'h1, "async class");
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_CLKOK_BIT);
        apb(1'b1, dpcs_pkg::MODE_OFS, 32'h0);
        wait_idle;
        chk({28'h0, rd[3:0]}, {28'h0, dpcs_pkg::ST_IDLE}, "state idle");
        chk({31'h0, rd[7]}, 32'h0, "sync class");
        chk({30'h0, clk_sel, cke}, {30'h0, ~sel0, 1'b1}, "new clock");
        chk({24'h0, dll}, {24'h0, dll0 + 8'h01}, "dll reset");
        apb(1'b0, dpcs_pkg::MODE_OFS, 32'h0);
        chk(rd, 32'h0044_1000, "busy write refused");
        $display("test freq change done");
    endtask : t_fchg
    task t_ckerst;
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_ODTON_BIT);
        dll0 = dll;
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_RST_BIT);
        wait_clk_off;
        chk({30'h0, cke, odt}, 32'h0, "reset cke odt");
        apb(1'b0, dpcs_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[6]}, 32'h0, "odt disabled");
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_CLKOK_BIT);
        wait_idle;
        chk({31'h0, cke}, 32'h1, "cke up");
        chk({24'h0, dll}, {24'h0, dll0 + 8'h01}, "dll reset");
        apb(1'b1, dpcs_pkg::CTRL_OFS, 32'h1 << dpcs_pkg::CTRL_ODTON_BIT);
        repeat (3) @(posedge clk);
        chk({31'h0, odt}, 32'h0, "odt refused");
        $display("test cke reset done");
    endtask : t_ckerst
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        chk({26'h0, cke, odt, cmd}, {28'h0, dpcs_pkg::CMD_NOP}, "reset pins");
        rst_n <= 1'b1;
        t_regs;
        t_rtt;
        t_fchg;
        t_ckerst;
        chk({24'h0, viol}, 32'h0, "device rules");
        stop_test;
    end
endmodule : tb_dpcs_seq
`default_nettype wire
